//--- rtl/uart_ctrl_pkg.sv
// Purpose: Shared constants and types of the host serial port control block
// Assumes: Special-function registers are byte wide, addressed by an 8-bit port
// Notes: Bit positions index the control and status bytes
`default_nettype none

package uart_ctrl_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_STATUS = 8'hab;
   localparam logic [7:0] ADDR_CONTROL = 8'hac;
   localparam logic [7:0] ADDR_PRESCALE = 8'had;
   localparam logic [7:0] ADDR_DIVISOR = 8'hae;

   // Control byte fields
   localparam int unsigned CTL_WAKE = 7;
   localparam int unsigned CTL_FRAME = 6;
   localparam int unsigned CTL_TXSTOP = 4;
   localparam int unsigned CTL_RXSTOP = 3;
   localparam int unsigned CTL_TXEN = 2;
   localparam int unsigned CTL_RXEN = 1;
   localparam int unsigned CTL_SRST = 0;

   // Status byte fields
   localparam int unsigned STA_SET = 7;
   localparam int unsigned STA_NOPRE = 4;
   localparam int unsigned STA_OVER_EN = 3;
   localparam int unsigned STA_FER_EN = 2;
   localparam int unsigned STA_OVER = 1;
   localparam int unsigned STA_FER = 0;
   localparam logic [7:0] STA_WMASK = 8'h1f;

   // Reset values
   localparam logic [7:0] CONTROL_RST = 8'h01;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] PRESCALE_RST = 8'h18;
   localparam logic [7:0] DIVISOR_RST = 8'h70;

   // Wake counter, preamble and last data bit index
   localparam logic [2:0] WAKE_EDGES = 3'h5;
   localparam logic [7:0] PRE_LEAD = 8'h00;
   localparam logic [7:0] PRE_TAIL = 8'hff;
   localparam logic [1:0] PRE_LEADS = 2'h2;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;

   // Receive buffer shape
   localparam int CHAR_W = 8;
   localparam int FIFO_DEPTH = 16;

   // Register port request
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef enum logic [3:0] {
      RX_IDLE = 4'h1,
      RX_START = 4'h2,
      RX_DATA = 4'h4,
      RX_STOP = 4'h8
   } rx_state_t;

   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_START = 4'h2,
      TX_DATA = 4'h4,
      TX_STOP = 4'h8
   } tx_state_t;

endpackage : uart_ctrl_pkg

`default_nettype wire

//--- rtl/char_fifo.sv
// Purpose: Character buffer between receiver and the FIFO manager
// Assumes: DEPTH is a power of two
// Notes: Read data leave through a registered output stage
`timescale 1ns/100ps
`default_nettype none

module char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
      logic in_ready;
      logic out_valid;
      logic [WIDTH-1:0] out_data;
   } fifo_t;

   fifo_t f_q;
   fifo_t f_d;
   logic push;
   logic pop;

   always_comb begin
      f_d = f_q;
      push = in_valid && f_q.in_ready;
      pop = (f_q.count != '0) && (!f_q.out_valid || out_ready);
      if (push) begin
         f_d.mem[f_q.wr] = in_data;
         f_d.wr = AW'(f_q.wr + 1'b1);
      end
      if (pop) begin
         f_d.out_data = f_q.mem[f_q.rd];
         f_d.out_valid = 1'b1;
         f_d.rd = AW'(f_q.rd + 1'b1);
      end else if (out_ready) begin
         f_d.out_valid = 1'b0;
      end
      if (push && !pop) begin
         f_d.count = (AW+1)'(f_q.count + 1'b1);
      end else if (pop && !push) begin
         f_d.count = (AW+1)'(f_q.count - 1'b1);
      end
      // Full when storage holds DEPTH words
      f_d.in_ready = f_d.count != (AW+1)'(DEPTH);
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         f_q <= '0;
         f_q.in_ready <= 1'b1;
      end else begin
         f_q <= f_d;
      end
   end

   assign in_ready = f_q.in_ready;
   assign out_valid = f_q.out_valid;
   assign out_data = f_q.out_data;

endmodule : char_fifo

`default_nettype wire

//--- rtl/host_uart_control.sv
// Purpose: Control, wake-up, preamble filter and serial engines of the host port
// Assumes: All inputs synchronous to core_clk; register reads return one cycle late
// Notes: Received characters pass through a 16-word buffer to the FIFO manager
// Function
// - Writing one to the wake bit restarts the receive-line rising-edge counter.
// - Counter reaching five raises the wake request toward the power controller.
// - CPU interrupt only rises while the external interrupt allow bit is one.
// - Writing the frame bit re-arms the preamble filter for the next frame.
// - Transmitter sends transmit-stop field plus one stop bits.
// - Receiver expects receive-stop bit plus one stop bits.
// - Transmit enable lets the transmitter send characters.
// - Clearing transmit enable stops only after the current character.
// - Receive enable lets the receiver accept characters.
// - Clearing receive enable stops only after the current character.
// - Soft reset low stops receive, transmit and baud generator logic.
// - Armed filter withholds characters until 00 00 FF has arrived.
// - Bit time is prescaler plus one times divisor, in clock cycles.
// - A stop bit sampled low sets the framing error flag.
`timescale 1ns/100ps
`default_nettype none

module host_uart_control
   import uart_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register port
   input wire sfr_req_t sfr,
   output logic [7:0] sfr_rdata,
   // Serial line
   input wire logic rxd,
   output logic txd,
   // Characters to send
   input wire logic tx_valid,
   input wire logic [CHAR_W-1:0] tx_char,
   output logic tx_ready,
   // Characters received
   output logic rx_valid,
   output logic [CHAR_W-1:0] rx_char,
   input wire logic rx_ready,
   // System
   input wire logic cpu_irq_allow,
   output logic cpu_irq,
   output logic wake_request
);

   typedef struct packed {
      logic [7:0] control;
      logic [7:0] status;
      logic [7:0] prescale;
      logic [7:0] divisor;
      logic [7:0] rdata;
      logic rxd_prev;
      logic [2:0] wake_cnt;
      logic wake_req;
      logic irq;
      logic pre_armed;
      logic [1:0] pre_match;
      rx_state_t rx_state;
      logic [16:0] rx_cnt;
      logic [3:0] rx_bits;
      logic [7:0] rx_shift;
      logic rx_bad;
      logic push_valid;
      logic [7:0] push_data;
      tx_state_t tx_state;
      logic [16:0] tx_cnt;
      logic [3:0] tx_bits;
      logic [7:0] tx_shift;
      logic txd;
      logic tx_ready;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [16:0] period;
   logic [16:0] bit_last;
   logic [16:0] half_last;
   logic srst_n;
   logic rx_end;
   logic tx_end;
   logic fifo_in_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Bit timing

   assign period = 17'(({9'h000, s_q.prescale} + 17'h00001) * {9'h000, s_q.divisor});
   assign bit_last = (period == '0) ? '0 : 17'(period - 17'h00001);
   assign half_last = period >> 1;
   assign srst_n = s_q.control[CTL_SRST];
   assign rx_end = s_q.rx_cnt >= bit_last;
   assign tx_end = s_q.tx_cnt >= bit_last;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_d = s_q;
      s_d.push_valid = 1'b0;
      s_d.rxd_prev = rxd;

      // Receiver
      unique case (s_q.rx_state)
         RX_IDLE: begin
            if (s_q.control[CTL_RXEN] && s_q.rxd_prev && !rxd) begin
               s_d.rx_state = RX_START;
               s_d.rx_cnt = '0;
               s_d.rx_bad = 1'b0;
            end
         end
         RX_START: begin
            if (s_q.rx_cnt >= half_last) begin
               s_d.rx_state = rxd ? RX_IDLE : RX_DATA;
               s_d.rx_cnt = '0;
               s_d.rx_bits = '0;
            end else begin
               s_d.rx_cnt = 17'(s_q.rx_cnt + 1'b1);
            end
         end
         RX_DATA: begin
            if (rx_end) begin
               s_d.rx_cnt = '0;
               s_d.rx_shift = {rxd, s_q.rx_shift[7:1]};
               s_d.rx_bits = 4'(s_q.rx_bits + 1'b1);
               if (s_q.rx_bits == LAST_DATA_BIT) begin
                  s_d.rx_state = RX_STOP;
                  s_d.rx_bits = '0;
               end
            end else begin
               s_d.rx_cnt = 17'(s_q.rx_cnt + 1'b1);
            end
         end
         RX_STOP: begin
            if (rx_end) begin
               s_d.rx_cnt = '0;
               s_d.rx_bits = 4'(s_q.rx_bits + 1'b1);
               if (!rxd) begin
                  s_d.rx_bad = 1'b1;
               end
               if (s_q.rx_bits == {3'h0, s_q.control[CTL_RXSTOP]}) begin
                  s_d.rx_state = RX_IDLE;
                  // Preamble filter on a well framed character
                  if (rxd && !s_q.rx_bad) begin
                     s_d.push_valid = !s_q.pre_armed || s_q.status[STA_NOPRE];
                     s_d.push_data = s_q.rx_shift;
                     if (s_q.rx_shift == PRE_TAIL && s_q.pre_match == PRE_LEADS) begin
                        s_d.pre_armed = 1'b0;
                     end else if (s_q.rx_shift == PRE_LEAD) begin
                        s_d.pre_match = (s_q.pre_match == PRE_LEADS) ? PRE_LEADS
                           : 2'(s_q.pre_match + 1'b1);
                     end else begin
                        s_d.pre_match = '0;
                     end
                  end
               end
            end else begin
               s_d.rx_cnt = 17'(s_q.rx_cnt + 1'b1);
            end
         end
      endcase

      // Transmitter
      unique case (s_q.tx_state)
         TX_IDLE: begin
            if (s_q.tx_ready && tx_valid) begin
               s_d.tx_state = TX_START;
               s_d.tx_shift = tx_char;
               s_d.tx_cnt = '0;
               s_d.txd = 1'b0;
            end
         end
         TX_START: begin
            if (tx_end) begin
               s_d.tx_state = TX_DATA;
               s_d.tx_cnt = '0;
               s_d.tx_bits = '0;
               s_d.txd = s_q.tx_shift[0];
            end else begin
               s_d.tx_cnt = 17'(s_q.tx_cnt + 1'b1);
            end
         end
         TX_DATA: begin
            if (tx_end) begin
               s_d.tx_cnt = '0;
               s_d.tx_shift = s_q.tx_shift >> 1;
               s_d.txd = s_q.tx_shift[1];
               s_d.tx_bits = 4'(s_q.tx_bits + 1'b1);
               if (s_q.tx_bits == LAST_DATA_BIT) begin
                  s_d.tx_state = TX_STOP;
                  s_d.tx_bits = '0;
                  s_d.txd = 1'b1;
               end
            end else begin
               s_d.tx_cnt = 17'(s_q.tx_cnt + 1'b1);
            end
         end
         TX_STOP: begin
            if (tx_end) begin
               s_d.tx_cnt = '0;
               s_d.tx_bits = 4'(s_q.tx_bits + 1'b1);
               if (s_q.tx_bits == {2'h0, s_q.control[CTL_TXSTOP +: 2]}) begin
                  s_d.tx_state = TX_IDLE;
               end
            end else begin
               s_d.tx_cnt = 17'(s_q.tx_cnt + 1'b1);
            end
         end
      endcase

      // Soft reset holds engines and baud counters
      if (!srst_n) begin
         s_d.rx_state = RX_IDLE;
         s_d.tx_state = TX_IDLE;
         s_d.rx_cnt = '0;
         s_d.tx_cnt = '0;
         s_d.txd = 1'b1;
         s_d.push_valid = 1'b0;
      end

      // Wake-up edge counter, saturating at the trigger count
      if (rxd && !s_q.rxd_prev && s_q.wake_cnt != WAKE_EDGES) begin
         s_d.wake_cnt = 3'(s_q.wake_cnt + 1'b1);
      end

      // Register writes
      if (sfr.wr) begin
         case (sfr.addr)
            ADDR_CONTROL: begin
               s_d.control = sfr.wdata;
               if (sfr.wdata[CTL_WAKE]) begin
                  s_d.wake_cnt = '0;
                  s_d.wake_req = 1'b0;
               end
               if (sfr.wdata[CTL_FRAME]) begin
                  s_d.pre_armed = 1'b1;
                  s_d.pre_match = '0;
               end
            end
            ADDR_STATUS: begin
               if (sfr.wdata[STA_SET]) begin
                  s_d.status = s_q.status | (sfr.wdata & STA_WMASK);
               end else begin
                  s_d.status = s_q.status & ~(sfr.wdata & STA_WMASK);
               end
            end
            ADDR_PRESCALE: s_d.prescale = sfr.wdata;
            ADDR_DIVISOR: s_d.divisor = sfr.wdata;
            default: ;
         endcase
      end

      // Error flags win over software clears; wake request follows the count after writes
      if (s_d.wake_cnt == WAKE_EDGES) begin
         s_d.wake_req = 1'b1;
      end
      if (s_q.rx_state == RX_STOP && rx_end && !rxd) begin
         s_d.status[STA_FER] = 1'b1;
      end
      if (s_q.push_valid && !fifo_in_ready) begin
         s_d.status[STA_OVER] = 1'b1;
      end

      s_d.irq = cpu_irq_allow && ((s_d.status[STA_FER] && s_d.status[STA_FER_EN])
         || (s_d.status[STA_OVER] && s_d.status[STA_OVER_EN]));
      s_d.tx_ready = (s_d.tx_state == TX_IDLE) && s_d.control[CTL_TXEN]
         && s_d.control[CTL_SRST];

      // Read data for the address on the port
      case (sfr.addr)
         ADDR_STATUS: s_d.rdata = s_d.status & STA_WMASK;
         ADDR_CONTROL: s_d.rdata = s_d.control;
         ADDR_PRESCALE: s_d.rdata = s_d.prescale;
         ADDR_DIVISOR: s_d.rdata = s_d.divisor;
         default: s_d.rdata = '0;
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
         s_q.control <= CONTROL_RST;
         s_q.status <= STATUS_RST;
         s_q.prescale <= PRESCALE_RST;
         s_q.divisor <= DIVISOR_RST;
         s_q.rxd_prev <= 1'b1;
         s_q.pre_armed <= 1'b1;
         s_q.rx_state <= RX_IDLE;
         s_q.tx_state <= TX_IDLE;
         s_q.txd <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive buffer

   char_fifo #(
      .WIDTH(CHAR_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .in_valid(s_q.push_valid),
      .in_data(s_q.push_data),
      .in_ready(fifo_in_ready),
      .out_valid(rx_valid),
      .out_data(rx_char),
      .out_ready(rx_ready)
   );

   assign sfr_rdata = s_q.rdata;
   assign txd = s_q.txd;
   assign tx_ready = s_q.tx_ready;
   assign cpu_irq = s_q.irq;
   assign wake_request = s_q.wake_req;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   sequence wake_write_s;
      sfr.wr && sfr.addr == ADDR_CONTROL && sfr.wdata[CTL_WAKE];
   endsequence

   sequence frame_write_s;
      sfr.wr && sfr.addr == ADDR_CONTROL && sfr.wdata[CTL_FRAME];
   endsequence

   wake_rearm_a: assert property (wake_write_s |=> !wake_request && s_q.wake_cnt <= 3'h1)
      else $error("wake counter not restarted");
   wake_raise_a: assert property (s_q.wake_cnt == WAKE_EDGES |-> wake_request)
      else $error("wake request missing at count five");
   irq_gate_a: assert property (cpu_irq |-> $past(cpu_irq_allow))
      else $error("interrupt raised without allow");
   frame_arm_a: assert property (frame_write_s |=> s_q.pre_armed && s_q.pre_match == '0)
      else $error("preamble filter not re-armed");
   tx_stop_len_a: assert property (s_q.tx_state == TX_STOP |->
      txd && s_q.tx_bits <= {2'h0, s_q.control[CTL_TXSTOP +: 2]})
      else $error("transmit stop bit count wrong");
   rx_stop_len_a: assert property (s_q.rx_state == RX_STOP |->
      s_q.rx_bits <= {3'h0, s_q.control[CTL_RXSTOP]})
      else $error("receive stop bit count wrong");
   tx_start_a: assert property ($rose(s_q.tx_state == TX_START) |-> $past(s_q.control[CTL_TXEN]))
      else $error("transmit started while disabled");
   tx_finish_a: assert property (s_q.tx_state == TX_DATA && srst_n && !tx_end
      |=> s_q.tx_state == TX_DATA)
      else $error("transmit character cut short");
   rx_start_a: assert property ($rose(s_q.rx_state == RX_START) |-> $past(s_q.control[CTL_RXEN]))
      else $error("receive started while disabled");
   rx_finish_a: assert property (s_q.rx_state == RX_DATA && srst_n && !rx_end
      |=> s_q.rx_state == RX_DATA)
      else $error("receive character cut short");
   soft_idle_a: assert property (!srst_n |=> s_q.tx_state == TX_IDLE
      && s_q.rx_state == RX_IDLE && txd && s_q.tx_cnt == '0)
      else $error("engines run during soft reset");
   filter_hold_a: assert property (s_q.push_valid |->
      !$past(s_q.pre_armed) || $past(s_q.status[STA_NOPRE]))
      else $error("character forwarded while filter armed");
   bit_time_a: assert property (s_q.tx_state != TX_IDLE |-> s_q.tx_cnt <= bit_last)
      else $error("bit counter beyond bit time");
   fer_set_a: assert property (s_q.rx_state == RX_STOP && rx_end && !rxd && srst_n
      |=> s_q.status[STA_FER])
      else $error("framing error not flagged");

endmodule : host_uart_control

`default_nettype wire

//--- dv/host_link_model.sv
// Purpose: Host-side partner on the serial line of the host port
// Assumes: Bit time in core_clk cycles comes from the bench
// Notes: Sender drives rxd, decoder records chars seen on txd
`timescale 1ns/100ps
`default_nettype none

module host_link_model (
   // Clock
   input wire logic core_clk,
   // Serial line
   output logic rxd,
   input wire logic txd,
   // Bit time
   input wire logic [15:0] bit_cycles
);
   logic [7:0] got_q[$];
   int cyc_q = 0;
   int start_q = 0;
   int gap_q = 0;

   initial rxd = 1'b1;
   always @(posedge core_clk) cyc_q <= cyc_q + 1;

   ////////////////////////////////////////
   // One char LSB first; last stop driven low on request
   task automatic send(input logic [7:0] b, input int stops, input bit bad);
      for (int i = 0; i <= 8 + stops; i++) begin
         @(posedge core_clk);
         rxd <= (i == 0) ? 1'b0 : (i <= 8) ? b[i-1] : !(bad && i == 8 + stops);
         repeat (bit_cycles - 1) @(posedge core_clk);
      end
      @(posedge core_clk) rxd <= 1'b1;
   endtask : send

   // Short low pulse, one rising edge
   task automatic pulse();
      @(posedge core_clk) rxd <= 1'b0;
      repeat (2) @(posedge core_clk);
      rxd <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask : pulse

   ////////////////////////////////////////
   // Mid-bit decoder; keeps start-to-start spacing
   initial begin : decode
      logic [7:0] v;
      forever begin
         @(negedge txd);
         gap_q = cyc_q - start_q;
         start_q = cyc_q;
         repeat (bit_cycles / 2) @(posedge core_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (bit_cycles) @(posedge core_clk);
            v[i] = txd;
         end
         repeat (bit_cycles) @(posedge core_clk);
         if (txd === 1'b1) got_q.push_back(v);
      end
   end
endmodule : host_link_model

`default_nettype wire

//--- dv/host_uart_control_tb.sv
// Purpose: Self-checking bench of the host serial port control block
// Assumes: Bit time shortened to four cycles (prescale 0, divisor 4)
// Notes: Partner model plays the host on the serial line
`timescale 1ns/100ps
`default_nettype none

module host_uart_control_tb
   import uart_ctrl_pkg::*;
;
   logic core_clk, reset, rxd, txd, tx_valid, tx_ready, rx_valid, rx_ready;
   logic cpu_irq_allow, cpu_irq, wake_request;
   sfr_req_t sfr;
   logic [7:0] sfr_rdata, tx_char, rx_char;
   logic [7:0] rxq[$];
   logic [7:0] pre[9] = '{8'h11, 8'h00, 8'h00, 8'hff, 8'h22, 8'h00, 8'h00, 8'hff, 8'h44};
   logic [7:0] fwd[5] = '{8'h22, 8'h00, 8'h00, 8'hff, 8'h44};
   int failures = 0;
   int checks = 0;
   int n, g;

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   host_uart_control i_dut (
      .core_clk(core_clk), .reset(reset), .sfr(sfr), .sfr_rdata(sfr_rdata),
      .rxd(rxd), .txd(txd), .tx_valid(tx_valid), .tx_char(tx_char),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_char(rx_char),
      .rx_ready(rx_ready), .cpu_irq_allow(cpu_irq_allow), .cpu_irq(cpu_irq),
      .wake_request(wake_request)
   );

   host_link_model i_host (
      .core_clk(core_clk), .rxd(rxd), .txd(txd), .bit_cycles(16'h0004)
   );

   always @(posedge core_clk) if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_char);

   ////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) sfr <= '{wr: 1'b1, addr: a, wdata: d};
      @(posedge core_clk) sfr.wr <= 1'b0;
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
      @(posedge core_clk) sfr <= '{wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge core_clk);
      #1 check(sfr_rdata & mask, exp);
   endtask : rdc

   task automatic tx(input logic [7:0] c);
      int i;
      i = 0;
      @(posedge core_clk);
      tx_valid <= 1'b1;
      tx_char <= c;
      do @(posedge core_clk); while (tx_ready !== 1'b1 && i++ < 400);
      check(8'(i > 400), 8'h00);
      tx_valid <= 1'b0;
   endtask : tx

   task automatic waitn(input int cnt, input bit from_rx);
      for (int i = 0; i < 3000; i++) begin
         if ((from_rx ? rxq.size() : i_host.got_q.size()) >= cnt) break;
         @(posedge core_clk);
      end
      check(8'((from_rx ? rxq.size() : i_host.got_q.size()) >= cnt), 8'h01);
   endtask : waitn

   task automatic test_done();
      $display("Checks %0d, failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done

   initial begin
      repeat (30000) @(posedge core_clk);
      failures++;
      $display("ERROR %0t: watchdog expired", $time);
      test_done();
   end

   ////////////////////////////////////////
   initial begin
      reset = 1'b1;
      sfr = '0;
      tx_valid = 1'b0;
      tx_char = 8'h00;
      rx_ready = 1'b1;
      cpu_irq_allow = 1'b0;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      check({7'h00, txd}, 8'h01);
      rdc(ADDR_CONTROL, 8'hff, 8'h01);
      rdc(ADDR_STATUS, 8'hff, 8'h00);
      rdc(ADDR_PRESCALE, 8'hff, 8'h18);
      rdc(ADDR_DIVISOR, 8'hff, 8'h70);
      wr(8'haa, 8'h5a);
      rdc(8'haa, 8'hff, 8'h00);
      check({7'h00, tx_ready}, 8'h00);
      wr(ADDR_PRESCALE, 8'h00);
      wr(ADDR_DIVISOR, 8'h04);
      rdc(ADDR_DIVISOR, 8'hff, 8'h04);
      $display("test registers done");
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_CONTROL, 8'h07 | 8'(s << 4));
         n = i_host.got_q.size();
         tx(8'h96 ^ 8'(s));
         tx(8'h4b);
         waitn(n + 2, 1'b0);
         check(i_host.got_q[n], 8'h96 ^ 8'(s));
         check(i_host.got_q[n + 1], 8'h4b);
         g = i_host.gap_q - (10 + s) * 4;
         check(8'(g >= 0 && g <= 3), 8'h01);
         // Let the last stop bits finish before the field changes
         repeat (4 * s + 4) @(posedge core_clk);
      end
      wr(ADDR_CONTROL, 8'h07);
      n = i_host.got_q.size();
      tx(8'ha5);
      repeat (8) @(posedge core_clk);
      wr(ADDR_CONTROL, 8'h03);
      waitn(n + 1, 1'b0);
      check(i_host.got_q[n], 8'ha5);
      tx_valid <= 1'b1;
      repeat (80) @(posedge core_clk);
      check({7'h00, tx_ready}, 8'h00);
      check(8'(i_host.got_q.size() - n), 8'h01);
      tx_valid <= 1'b0;
      $display("test transmit done");
      wr(ADDR_STATUS, 8'h90);
      wr(ADDR_CONTROL, 8'h07);
      n = rxq.size();
      i_host.send(8'h5a, 1, 1'b0);
      waitn(n + 1, 1'b1);
      check(rxq[n], 8'h5a);
      wr(ADDR_CONTROL, 8'h0f);
      i_host.send(8'h66, 2, 1'b1);
      i_host.send(8'h77, 2, 1'b0);
      waitn(n + 2, 1'b1);
      check(rxq[n + 1], 8'h77);
      rdc(ADDR_STATUS, 8'h01, 8'h01);
      wr(ADDR_STATUS, 8'h84);
      rdc(ADDR_STATUS, 8'hff, 8'h15);
      check({7'h00, cpu_irq}, 8'h00);
      @(posedge core_clk) cpu_irq_allow <= 1'b1;
      repeat (3) @(posedge core_clk);
      check({7'h00, cpu_irq}, 8'h01);
      wr(ADDR_STATUS, 8'h01);
      repeat (3) @(posedge core_clk);
      check({7'h00, cpu_irq}, 8'h00);
      wr(ADDR_CONTROL, 8'h07);
      n = rxq.size();
      fork
         i_host.send(8'h2d, 1, 1'b0);
         begin
            repeat (12) @(posedge core_clk);
            wr(ADDR_CONTROL, 8'h05);
         end
      join
      waitn(n + 1, 1'b1);
      check(rxq[n], 8'h2d);
      i_host.send(8'h4e, 1, 1'b0);
      repeat (8) @(posedge core_clk);
      check(8'(rxq.size() - n), 8'h01);
      $display("test receive done");
      wr(ADDR_STATUS, 8'h10);
      wr(ADDR_CONTROL, 8'h47);
      n = rxq.size();
      foreach (pre[i]) i_host.send(pre[i], 1, 1'b0);
      repeat (8) @(posedge core_clk);
      check(8'(rxq.size() - n), 8'h05);
      foreach (fwd[i]) check(rxq[n + i], fwd[i]);
      $display("test preamble done");
      // Fill the buffer with the consumer stalled, then drain it
      rx_ready <= 1'b0;
      n = rxq.size();
      for (int i = 0; i < 18; i++) i_host.send(8'(i), 1, 1'b0);
      repeat (8) @(posedge core_clk);
      check({7'h00, rx_valid}, 8'h01);
      rdc(ADDR_STATUS, 8'h02, 8'h02);
      wr(ADDR_STATUS, 8'h88);
      repeat (2) @(posedge core_clk);
      check({7'h00, cpu_irq}, 8'h01);
      wr(ADDR_STATUS, 8'h0a);
      repeat (2) @(posedge core_clk);
      check({7'h00, cpu_irq}, 8'h00);
      @(posedge core_clk) rx_ready <= 1'b1;
      repeat (40) @(posedge core_clk);
      check(8'(rxq.size() - n >= 16 && rxq.size() - n <= 17), 8'h01);
      check(rxq[n], 8'h00);
      check({7'h00, rx_valid}, 8'h00);
      $display("test buffer done");
      wr(ADDR_CONTROL, 8'h06);
      rdc(ADDR_CONTROL, 8'hff, 8'h06);
      n = rxq.size();
      g = i_host.got_q.size();
      @(posedge core_clk) tx_valid <= 1'b1;
      i_host.send(8'h39, 1, 1'b0);
      check({6'h00, tx_ready, txd}, 8'h01);
      check(8'(rxq.size() - n), 8'h00);
      check(8'(i_host.got_q.size() - g), 8'h00);
      @(posedge core_clk) tx_valid <= 1'b0;
      $display("test soft reset done");
      wr(ADDR_CONTROL, 8'h81);
      repeat (2) @(posedge core_clk);
      check({7'h00, wake_request}, 8'h00);
      repeat (4) i_host.pulse();
      repeat (4) @(posedge core_clk);
      check({7'h00, wake_request}, 8'h00);
      i_host.pulse();
      repeat (4) @(posedge core_clk);
      check({7'h00, wake_request}, 8'h01);
      wr(ADDR_CONTROL, 8'h81);
      repeat (2) @(posedge core_clk);
      check({7'h00, wake_request}, 8'h00);
      $display("test wake done");
      test_done();
   end
endmodule : host_uart_control_tb

`default_nettype wire
